// ==== rtl/front_panel.sv ====
// front panel indicator and local command logic with axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module front_panel
	import panel_pkg::*;
#(
	parameter int          NUM_CMD        = 3,
	parameter int unsigned BLINK_HALF     = BLINK_HALF_CYC,
	parameter int unsigned HOLD_CYCLES    = HOLD_CYC,
	parameter int unsigned RESTORE_CYCLES = RESTORE_CYC
)(
	input  wire logic               aclk,          // system clock
	input  wire logic               aresetn,       // sync reset, active low
	input  wire logic [7:0]         s_axi_awaddr,  // write address
	input  wire logic               s_axi_awvalid, // write address valid
	output logic                    s_axi_awready, // write address ready
	input  wire logic [31:0]        s_axi_wdata,   // write data
	input  wire logic [3:0]         s_axi_wstrb,   // write byte strobes
	input  wire logic               s_axi_wvalid,  // write data valid
	output logic                    s_axi_wready,  // write data ready
	output logic [1:0]              s_axi_bresp,   // write response
	output logic                    s_axi_bvalid,  // write response valid
	input  wire logic               s_axi_bready,  // write response ready
	input  wire logic [7:0]         s_axi_araddr,  // read address
	input  wire logic               s_axi_arvalid, // read address valid
	output logic                    s_axi_arready, // read address ready
	output logic [31:0]             s_axi_rdata,   // read data
	output logic [1:0]              s_axi_rresp,   // read response
	output logic                    s_axi_rvalid,  // read data valid
	input  wire logic               s_axi_rready,  // read data ready
	input  wire logic [NUM_DI-1:0]  di_pin,        // digital input pins
	input  wire logic [NUM_CMD-1:0] cmd_btn,       // command buttons
	input  wire logic               confirm_btn,   // confirmation button
	output logic [NUM_LEDS-1:0]     led_red,       // configurable leds
	output logic                    ready_green,   // ready led green
	output logic                    ready_red,     // ready led red
	output logic                    local_led,     // indicator 18
	output logic                    remote_led,    // indicator 19
	output logic                    led20,         // indicator 20
	output logic [NUM_CMD-1:0]      cmd_led,       // command button leds
	output logic                    confirm_led,   // confirm button led
	output logic [NUM_CMD-1:0]      cmd_exec,      // confirmed command pulse
	output logic [NUM_CMD-1:0]      cmd_state,     // commanded status
	output logic                    restore_busy   // default restore running
);

	typedef struct packed {
		panel_state_type                st;
		logic [31:0]                    blink_cnt;
		logic                           blink_ph;
		logic [4:0]                     step;
		logic [31:0]                    hold_cnt;
		logic                           hold_block;
		logic [31:0]                    rest_cnt;
		logic [3:0]                     ctrl;
		logic [2:0]                     di_sel;
		logic [31:0]                    prescale;
		logic [NUM_LEDS-1:0]            blink_mode;
		logic [NUM_LEDS-1:0]            latch_en;
		logic [SIG_W-1:0]               sigs;
		logic [NUM_LEDS-1:0][CFG_W-1:0] or_cfg;
		logic [NUM_LEDS-1:0][CFG_W-1:0] and_cfg;
		logic                           led_rst;
		logic                           sel_valid;
		logic [NUM_CMD-1:0]             sel;
		logic [NUM_CMD:0]               btn_prev;
		logic [NUM_CMD-1:0]             exec;
		logic [NUM_CMD-1:0]             cstate;
		logic                           aw_got;
		logic [7:0]                     awaddr;
		logic                           w_got;
		logic [31:0]                    wdata;
		logic [3:0]                     wstrb;
		logic                           awready;
		logic                           wready;
		logic                           bvalid;
		logic [1:0]                     bresp;
		logic                           arready;
		logic                           rvalid;
		logic [31:0]                    rdata;
		logic [1:0]                     rresp;
		logic [NUM_LEDS-1:0]            leds;
		logic                           rdy_g;
		logic                           rdy_r;
		logic                           loc;
		logic                           rem;
		logic [NUM_CMD-1:0]             cled;
	} panel_reg_type;

	panel_reg_type       q;
	panel_reg_type       d;
	logic [NUM_DI-1:0]   di_s;
	logic [NUM_CMD:0]    btn_s;
	logic [NUM_CMD:0]    btn_rise;
	logic [31:0]         src;
	logic [NUM_LEDS-1:0] lit;
	logic                tick;
	logic [31:0]         wm;
	logic [31:0]         nv;
	logic [31:0]         rv;
	logic [3:0]          ci;
	logic                hit;

	// pins come from outside the clock domain
	pin_sync #(.WIDTH(NUM_DI)) u_di_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     (di_pin),
		.level   (di_s)
	);

	pin_sync #(.WIDTH(NUM_CMD + 1)) u_btn_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     ({confirm_btn, cmd_btn}),
		.level   (btn_s)
	);

	// top source bit is the unassigned selector and always reads low
	assign src = {1'b0, di_s, q.sigs};

	for (genvar i = 0; i < NUM_LEDS; i++)
	begin : g_led
		led_channel u_chan (
			.aclk       (aclk),
			.aresetn    (aresetn),
			.src        (src),
			.or_sel     (q.or_cfg[i]),
			.and_sel    (q.and_cfg[i]),
			.blink_mode (q.blink_mode[i]),
			.latch_en   (q.latch_en[i]),
			.clear      (q.led_rst),
			.blink_ph   (q.blink_ph),
			.lit        (lit[i])
		);
	end

	always_comb
	begin
		d = q;
		tick = 1'b0;
		wm = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}},
			{8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
		nv = 32'h0000_0000;
		rv = 32'h0000_0000;
		ci = 4'(q.awaddr[6:3] - 4'h8);
		hit = 1'b1;
		d.led_rst = 1'b0;
		d.exec = '0;
		btn_rise = btn_s & ~q.btn_prev;
		d.btn_prev = btn_s;

		// shared prescaler: one blink period for every indicator
		if (q.blink_cnt >= q.prescale)
		begin
			d.blink_cnt = 32'h0000_0000;
			d.blink_ph = ~q.blink_ph;
			tick = 1'b1;
		end
		else
			d.blink_cnt = q.blink_cnt + 32'h0000_0001;

		// write channels are taken independently, answered once both are in
		if (q.awready && s_axi_awvalid)
		begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (q.wready && s_axi_wvalid)
		begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		if (q.aw_got && q.w_got && !q.bvalid)
		begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			case (q.awaddr)
				OFF_CTRL:
				begin
					nv = q.wdata & wm;
					d.ctrl = nv[3:0];
					d.di_sel = nv[CTRL_DISEL_LSB +: 3];
					if (nv[CTRL_LEDRST_BIT])
						d.led_rst = 1'b1;
				end
				OFF_PRESCALE:
					d.prescale = (q.prescale & ~wm) | (q.wdata & wm);
				OFF_BLINK:
					d.blink_mode = NUM_LEDS'((q.wdata & wm)
						| ({16'h0000, q.blink_mode} & ~wm));
				OFF_LATCH:
					d.latch_en = NUM_LEDS'((q.wdata & wm)
						| ({16'h0000, q.latch_en} & ~wm));
				OFF_SIGNALS:
					d.sigs = SIG_W'((q.wdata & wm)
						| ({9'h000, q.sigs} & ~wm));
				OFF_STATUS, OFF_CMD: ;
				default:
				begin
					if (q.awaddr >= OFF_CFG_BASE && q.awaddr < OFF_CFG_END)
					begin
						if (q.awaddr[2])
							d.and_cfg[ci] = CFG_W'((q.wdata & wm)
								| ({2'h0, q.and_cfg[ci]} & ~wm));
						else
							d.or_cfg[ci] = CFG_W'((q.wdata & wm)
								| ({2'h0, q.or_cfg[ci]} & ~wm));
					end
					else
						hit = 1'b0;
				end
			endcase
			d.bresp = hit ? RESP_OKAY : RESP_SLVERR;
		end

		// read address answered one cycle later, held until rready
		if (q.rvalid && s_axi_rready)
			d.rvalid = 1'b0;
		if (q.arready && s_axi_arvalid)
		begin
			ci = 4'(s_axi_araddr[6:3] - 4'h8);
			hit = 1'b1; // a failed write this cycle must not mark the read
			case (s_axi_araddr)
				OFF_CTRL:
					rv = {21'h000000, q.di_sel, 4'h0, q.ctrl};
				OFF_PRESCALE:
					rv = q.prescale;
				OFF_BLINK:
					rv = {16'h0000, q.blink_mode};
				OFF_LATCH:
					rv = {16'h0000, q.latch_en};
				OFF_SIGNALS:
					rv = {9'h000, q.sigs};
				OFF_STATUS:
					rv = {5'h00, q.st, q.leds, q.rdy_g, q.rdy_r,
						q.loc, q.rem, 3'h0, q.sel_valid};
				OFF_CMD:
					rv = {8'h00, 8'(q.sel), 8'(q.cstate), 8'(q.cled)};
				default:
				begin
					if (s_axi_araddr >= OFF_CFG_BASE
						&& s_axi_araddr < OFF_CFG_END)
						rv = {2'h0, s_axi_araddr[2] ? q.and_cfg[ci]
							: q.or_cfg[ci]};
					else
						hit = 1'b0;
				end
			endcase
			d.rvalid = 1'b1;
			d.rdata = rv;
			d.rresp = hit ? RESP_OKAY : RESP_SLVERR;
		end

		// a digital input may be set up as the led reset source
		if (q.ctrl[CTRL_DIRST_BIT] && di_s[q.di_sel])
			d.led_rst = 1'b1;

		case (q.st)
			// power-up carousel walks the indicators one per blink step
			ST_TEST:
			begin
				if (tick)
				begin
					if (q.step == 5'(TEST_STEPS - 1))
					begin
						d.step = 5'h00;
						d.st = ST_RUN;
					end
					else
						d.step = q.step + 5'h01;
				end
			end
			ST_RUN:
			begin
				if (btn_rise[NUM_CMD] && q.sel_valid)
				begin
					d.exec = q.sel;
					d.cstate = q.cstate ^ q.sel;
					d.sel_valid = 1'b0;
					d.sel = '0;
				end
				// a newer selection replaces an unconfirmed one and
				// survives a confirm landing in the same cycle
				for (int b = 0; b < NUM_CMD; b++)
				begin
					if (btn_rise[b])
					begin
						d.sel_valid = 1'b1;
						d.sel = '0;
						d.sel[b] = 1'b1;
					end
				end
				// the hold must be released once before it counts again
				if (!btn_s[NUM_CMD])
				begin
					d.hold_cnt = 32'h0000_0000;
					d.hold_block = 1'b0;
				end
				else if (!q.hold_block)
				begin
					if (q.hold_cnt >= HOLD_CYCLES - 1)
					begin
						d.st = ST_RESTORE;
						d.hold_cnt = 32'h0000_0000;
						d.rest_cnt = 32'h0000_0000;
					end
					else
						d.hold_cnt = q.hold_cnt + 32'h0000_0001;
				end
			end
			ST_RESTORE:
			begin
				// defaults land on every setting, overriding any bus write
				d.ctrl = CTRL_RST;
				d.di_sel = 3'h0;
				d.prescale = BLINK_HALF;
				d.blink_mode = '0;
				d.latch_en = '0;
				d.sigs = '0;
				for (int k = 0; k < NUM_LEDS; k++)
				begin
					d.or_cfg[k] = CFG_RST;
					d.and_cfg[k] = CFG_RST;
				end
				d.cstate = '0;
				d.sel_valid = 1'b0;
				d.sel = '0;
				d.led_rst = 1'b1;
				if (q.rest_cnt >= RESTORE_CYCLES - 1)
				begin
					d.st = ST_RUN;
					d.hold_block = 1'b1;
				end
				else
					d.rest_cnt = q.rest_cnt + 32'h0000_0001;
			end
			default:
				d.st = ST_TEST;
		endcase

		d.awready = !d.aw_got && !d.bvalid;
		d.wready = !d.w_got && !d.bvalid;
		d.arready = !d.rvalid;

		// indicator drive, registered so the pins never glitch
		case (d.st)
			ST_TEST:
			begin
				d.leds = (d.step < 5'd16) ? NUM_LEDS'(1) << d.step : '0;
				d.loc = (d.step == 5'd16);
				d.rem = (d.step == 5'd17);
				d.rdy_g = d.blink_ph;
				d.rdy_r = 1'b0;
				d.cled = '0;
			end
			ST_RESTORE:
			begin
				d.leds = '1;
				d.loc = 1'b1;
				d.rem = 1'b1;
				d.rdy_g = 1'b0;
				d.rdy_r = 1'b0;
				d.cled = '1;
			end
			default:
			begin
				d.leds = lit;
				d.loc = !d.ctrl[CTRL_REMOTE_BIT];
				d.rem = d.ctrl[CTRL_REMOTE_BIT];
				d.rdy_r = d.ctrl[CTRL_ERR_BIT];
				d.rdy_g = !d.ctrl[CTRL_ERR_BIT]
					&& (d.ctrl[CTRL_RUN_BIT] || d.blink_ph);
				for (int b = 0; b < NUM_CMD; b++)
					d.cled[b] = (d.sel_valid && d.sel[b]) ? d.blink_ph
						: d.cstate[b];
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
			q.st <= ST_TEST;
			q.prescale <= BLINK_HALF;
			q.or_cfg <= {NUM_LEDS{CFG_RST}};
			q.and_cfg <= {NUM_LEDS{CFG_RST}};
			q.ctrl <= CTRL_RST;
		end
		else
			q <= d;
	end

	assign s_axi_awready = q.awready;
	assign s_axi_wready  = q.wready;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;
	assign led_red       = q.leds;
	assign ready_green   = q.rdy_g;
	assign ready_red     = q.rdy_r;
	assign local_led     = q.loc;
	assign remote_led    = q.rem;
	assign cmd_led       = q.cled;
	assign cmd_exec      = q.exec;
	assign cmd_state     = q.cstate;
	assign restore_busy  = q.st[2];
	// these two indicators are held dark by an and with a constant zero
	assign led20         = q.btn_prev[0] & 1'b0;
	assign confirm_led   = q.btn_prev[0] & 1'b0;

endmodule : front_panel

// ==== rtl/panel_pkg.sv ====
// shared constants, register map and state codes for the front panel logic
package panel_pkg;

	// clock and timing
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned BLINK_HALF_MS   = 250;
	localparam int unsigned HOLD_S          = 5;
	localparam int unsigned RESTORE_MS      = 1000;
	localparam int unsigned BLINK_HALF_CYC  = BLINK_HALF_MS * (CLK_HZ / 1000);
	localparam int unsigned HOLD_CYC        = HOLD_S * CLK_HZ;
	localparam int unsigned RESTORE_CYC     = RESTORE_MS * (CLK_HZ / 1000);

	// structure of the indicator set
	localparam int NUM_LEDS   = 16;
	localparam int GROUP_SIZE = 6;
	localparam int SEL_W      = 5;
	localparam int CFG_W      = GROUP_SIZE * SEL_W;
	localparam int NUM_DI     = 8;
	localparam int SIG_W      = 31 - NUM_DI;
	localparam int TEST_STEPS = 18;
	localparam logic [SEL_W-1:0] SEL_NONE = 5'h1F;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_PRESCALE = 8'h04;
	localparam logic [7:0] OFF_BLINK    = 8'h08;
	localparam logic [7:0] OFF_LATCH    = 8'h0C;
	localparam logic [7:0] OFF_SIGNALS  = 8'h10;
	localparam logic [7:0] OFF_STATUS   = 8'h14;
	localparam logic [7:0] OFF_CMD      = 8'h18;
	localparam logic [7:0] OFF_CFG_BASE = 8'h40;
	localparam logic [7:0] OFF_CFG_END  = 8'hC0;

	// control register fields
	localparam int CTRL_RUN_BIT    = 0;
	localparam int CTRL_ERR_BIT    = 1;
	localparam int CTRL_REMOTE_BIT = 2;
	localparam int CTRL_DIRST_BIT  = 3;
	localparam int CTRL_LEDRST_BIT = 4;
	localparam int CTRL_DISEL_LSB  = 8;

	// reset values
	localparam logic [3:0]       CTRL_RST = 4'h0;
	localparam logic [CFG_W-1:0] CFG_RST  = 30'h3FFF_FFFF;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_TEST    = 3'b001,
		ST_RUN     = 3'b010,
		ST_RESTORE = 3'b100
	} panel_state_type;

endpackage : panel_pkg

// ==== rtl/pin_sync.sv ====
// two-stage synchroniser for front panel pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
)(
	input  wire logic             aclk,    // system clock
	input  wire logic             aresetn, // synchronous reset, active low
	input  wire logic [WIDTH-1:0] pin,     // asynchronous pin level
	output logic      [WIDTH-1:0] level    // synchronised level
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_type;

	sync_state_type q;
	sync_state_type d;

	// first stage feeds only the second stage
	always_comb
	begin
		d.meta   = pin;
		d.stable = q.meta;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			q <= '0;
		else
			q <= d;
	end

	assign level = q.stable;

endmodule : pin_sync

// ==== rtl/led_channel.sv ====
// one configurable indicator: or/and groups, blink and latch
`timescale 1ns/1ps
module led_channel
	import panel_pkg::*;
(
	input  wire logic             aclk,       // system clock
	input  wire logic             aresetn,    // synchronous reset, active low
	input  wire logic [31:0]      src,        // selectable source signals
	input  wire logic [CFG_W-1:0] or_sel,     // six or-group selectors
	input  wire logic [CFG_W-1:0] and_sel,    // six and-group selectors
	input  wire logic             blink_mode, // 1 blink, 0 steady
	input  wire logic             latch_en,   // hold after condition drops
	input  wire logic             clear,      // led reset command
	input  wire logic             blink_ph,   // shared blink phase
	output logic                  lit         // indicator drive
);

	typedef struct packed {
		logic latched;
	} chan_state_type;

	chan_state_type  q;
	chan_state_type  d;
	logic [GROUP_SIZE-1:0] or_hit;
	logic [GROUP_SIZE-1:0] and_ok;
	logic [GROUP_SIZE-1:0] and_used;
	logic            cond;
	logic            active;

	// each selector either names a source or is unassigned
	for (genvar g = 0; g < GROUP_SIZE; g++)
	begin : g_term
		logic [SEL_W-1:0] os;
		logic [SEL_W-1:0] as;
		assign os = or_sel[g*SEL_W +: SEL_W];
		assign as = and_sel[g*SEL_W +: SEL_W];
		assign or_hit[g]   = (os != SEL_NONE) && src[os];
		assign and_used[g] = (as != SEL_NONE);
		assign and_ok[g]   = !and_used[g] || src[as];
	end

	// an empty and-group never fires
	assign cond   = (|or_hit) || ((|and_used) && (&and_ok));
	assign active = cond || q.latched;

	// a set in the clear cycle wins so no activation is lost
	always_comb
	begin
		d = q;
		if (cond && latch_en)
			d.latched = 1'b1;
		else if (clear)
			d.latched = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			q <= '0;
		else
			q <= d;
	end

	// steady follows the condition, blink gates it with the shared phase
	assign lit = active && (blink_mode ? blink_ph : 1'b1);

endmodule : led_channel

// ==== dv/front_panel_props.sv ====
// checker on the front panel ports
`timescale 1ns/1ps
module front_panel_props
	import panel_pkg::*;
#(
	parameter int NUM_CMD = 3,
	parameter int HOLD_CYCLES = 20,
	parameter int RESTORE_CYCLES = 10
)(
	input logic aclk, // clock
	input logic aresetn, // reset, low
	input logic s_axi_awvalid, // aw valid
	input logic s_axi_awready, // aw ready
	input logic s_axi_wvalid, // w valid
	input logic s_axi_wready, // w ready
	input logic s_axi_bvalid, // b valid
	input logic s_axi_arvalid, // ar valid
	input logic s_axi_arready, // ar ready
	input logic s_axi_rvalid, // r valid
	input logic confirm_btn, // confirm button
	input logic [NUM_LEDS-1:0] led_red, // leds
	input logic ready_green, // ready green
	input logic ready_red, // ready red
	input logic local_led, // indicator 18
	input logic remote_led, // indicator 19
	input logic led20, // indicator 20
	input logic confirm_led, // confirm led
	input logic [NUM_CMD-1:0] cmd_exec, // command pulse
	input logic restore_busy // restore running
);
	int hold_q;
	int busy_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// press and restore lengths; the raw press runs ahead of the
	// synchronised copy, so a raw count of HOLD_CYCLES cycles or more reads long enough here
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hold_q <= 0;
			busy_q <= 0;
		end
		else
		begin
			hold_q <= confirm_btn ? hold_q + 1 : 0;
			busy_q <= restore_busy ? busy_q + 1 : 0;
		end
	end

	// bus hand-shakes and the restore lamp pattern
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence lamps_on;
		&led_red && local_led && remote_led && !ready_green && !ready_red;
	endsequence

	// fixed lamps, command pulse, restore and bus timing
	a_led20_dark: assert property (!led20)
		else $error("indicator 20 lit");
	a_confirm_dark: assert property (!confirm_led)
		else $error("confirm led lit");
	a_exec_pulse: assert property (|cmd_exec |=> cmd_exec == '0)
		else $error("command pulse too long");
	a_restore_lamps: assert property (
		restore_busy && $past(restore_busy) |-> lamps_on)
		else $error("wrong lamps in restore");
	a_restore_hold: assert property (
		$rose(restore_busy) |-> hold_q >= HOLD_CYCLES)
		else $error("restore without full hold");
	a_restore_len: assert property (
		$fell(restore_busy) |-> busy_q == RESTORE_CYCLES)
		else $error("restore length wrong");
	a_write_answer: assert property (wr_taken |-> ##[2:3] s_axi_bvalid)
		else $error("write not answered");
	a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read not answered");
endmodule : front_panel_props

// ==== dv/panel_operator.sv ====
// operator model pressing the panel buttons
`timescale 1ns/1ps
module panel_operator #(
	parameter int NUM_CMD = 3
)(
	input logic aclk, // clock
	output logic [NUM_CMD-1:0] cmd_btn, // command buttons
	output logic confirm_btn // confirmation button
);
	// a released button reads low
	initial
	begin
		cmd_btn = '0;
		confirm_btn = 1'b0;
	end

	// presses last long enough to pass the synchroniser
	task automatic press_cmd(input int b);
		cmd_btn[b] <= 1'b1;
		repeat (6) @(posedge aclk);
		cmd_btn[b] <= 1'b0;
		repeat (6) @(posedge aclk);
	endtask : press_cmd

	// confirms a selection; a long hold asks for defaults
	task automatic press_confirm(input int cycles);
		confirm_btn <= 1'b1;
		repeat (cycles) @(posedge aclk);
		confirm_btn <= 1'b0;
		repeat (6) @(posedge aclk);
	endtask : press_confirm
endmodule : panel_operator

// ==== dv/front_panel_tb.sv ====
// self-checking bench for the front panel logic
`timescale 1ns/1ps
module front_panel_tb;
	import panel_pkg::*;
	localparam int HOLD = 20;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, confirm_btn;
	logic confirm_led, restore_busy, ready_green, ready_red, led20;
	logic local_led, remote_led;
	logic [7:0] s_axi_awaddr, s_axi_araddr, di_pin;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0] cmd_btn, cmd_led, cmd_exec, cmd_state;
	logic [15:0] led_red;
	int n_errors, n_compared, t;

	front_panel #(.NUM_CMD(3), .BLINK_HALF(4), .HOLD_CYCLES(HOLD),
		.RESTORE_CYCLES(16)) uut (.*);
	panel_operator #(.NUM_CMD(3)) op (.aclk(aclk), .cmd_btn(cmd_btn),
		.confirm_btn(confirm_btn));

	// 50 ns clock
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("errors %0d, compares %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	// a wait that runs out ends the run as a failure
	task automatic hang();
		n_errors++;
		$display("ERROR %0t: wait ran out", $time);
		report_and_stop();
	endtask : hang

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc

	// both write channels offered at once, bready held until bvalid
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (int n = 0; n < 60; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				chk(32'(s_axi_bresp), 32'(er));
				s_axi_bready <= 1'b0;
				@(posedge aclk);
				return;
			end
		end
		hang();
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [1:0] er = RESP_OKAY);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (int n = 0; n < 60; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				rv = s_axi_rdata;
				chk(32'(s_axi_rresp), 32'(er));
				s_axi_rready <= 1'b0;
				@(posedge aclk);
				return;
			end
		end
		hang();
	endtask : rd

	// counts level changes of one lamp over 30 cycles
	task automatic toggles(input int s, output int n);
		logic p, v;
		n = 0;
		p = (s == 0) ? led_red[0] : (s == 1) ? ready_green : cmd_led[1];
		repeat (30)
		begin
			@(posedge aclk);
			v = (s == 0) ? led_red[0] : (s == 1) ? ready_green : cmd_led[1];
			n += int'(v !== p);
			p = v;
		end
	endtask : toggles

	task automatic blinks(input int s);
		toggles(s, t);
		chk(32'(t inside {[5:7]}), 32'h1);
	endtask : blinks

	// reset values and unmapped places
	task automatic t_regs();
		rd(OFF_CTRL);
		chk(rv, 32'h0);
		rd(OFF_PRESCALE);
		chk(rv, 32'h4);
		rd(8'hBC);
		chk(rv, {2'h0, CFG_RST});
		rd(8'hFC, RESP_SLVERR);
		chk(rv, 32'h0);
		wr(8'hFC, 32'hFFFFFFFF, RESP_SLVERR);
		// a write with no strobes leaves every byte alone
		s_axi_wstrb <= 4'h0;
		wr(OFF_PRESCALE, 32'hFFFFFFFF);
		s_axi_wstrb <= 4'hF;
		rd(OFF_PRESCALE);
		chk(rv, 32'h4);
		for (int i = 0; i < 50; i++)
		begin
			rd(OFF_STATUS);
			if (rv[26:24] === 3'h2) return;
		end
		hang();
	endtask : t_regs

	// or group in slot 5, and group in slots 0 and 5, steady and blink modes
	task automatic t_gates();
		logic [31:0] sv [5] = '{32'h1, 32'h2, 32'h6, 32'h4, 32'h0};
		logic [15:0] ex [5] = '{16'h1, 16'h0, 16'h1, 16'h0, 16'h0};
		wr(OFF_CFG_BASE, 32'h01FFFFFF);
		wr(OFF_CFG_BASE + 8'h04, 32'h05FFFFE1);
		foreach (sv[i])
		begin
			wr(OFF_SIGNALS, sv[i]);
			cyc(2);
			chk(32'(led_red), 32'(ex[i]));
		end
		wr(OFF_BLINK, 32'h1);
		wr(OFF_SIGNALS, 32'h1);
		blinks(0);
		wr(OFF_BLINK, 32'h0);
		cyc(2);
		toggles(0, t);
		chk(32'({t[7:0], led_red}), 32'h1);
	endtask : t_gates

	// latch cleared by command, then by a digital input
	task automatic t_latch();
		wr(OFF_LATCH, 32'h1);
		wr(OFF_SIGNALS, 32'h0);
		cyc(2);
		chk(32'(led_red), 32'h1);
		wr(OFF_CTRL, 32'h10);
		cyc(2);
		chk(32'(led_red), 32'h0);
		wr(OFF_SIGNALS, 32'h1);
		wr(OFF_SIGNALS, 32'h0);
		wr(OFF_CTRL, 32'h208);
		chk(32'(led_red), 32'h1);
		// only the chosen input may clear the latch
		di_pin <= 8'hFB;
		cyc(6);
		chk(32'(led_red), 32'h1);
		di_pin <= 8'hFF;
		cyc(6);
		chk(32'(led_red), 32'h0);
		di_pin <= 8'h00;
		wr(OFF_LATCH, 32'h0);
	endtask : t_latch

	// ready colours and local or remote lamps
	task automatic t_ready();
		wr(OFF_CTRL, 32'h1);
		toggles(1, t);
		chk(32'(t), 32'h0);
		chk(32'({ready_green, ready_red, local_led, remote_led}), 32'hA);
		wr(OFF_CTRL, 32'h7);
		cyc(2);
		chk(32'({ready_green, ready_red, local_led, remote_led}), 32'h5);
		wr(OFF_CTRL, 32'h0);
		blinks(1);
	endtask : t_ready

	// selection, confirmation, bare confirm and replaced selection
	task automatic t_cmd();
		op.press_cmd(1);
		blinks(2);
		chk(32'(cmd_state), 32'h0);
		op.press_confirm(6);
		chk(32'({cmd_led, cmd_state}), 32'h12);
		op.press_confirm(6);
		chk(32'(cmd_state), 32'h2);
		op.press_cmd(0);
		op.press_cmd(2);
		op.press_confirm(6);
		chk(32'(cmd_state), 32'h6);
	endtask : t_cmd

	// short hold is ignored, long hold restores defaults
	task automatic t_restore();
		op.press_confirm(10);
		chk(32'(restore_busy), 32'h0);
		wr(OFF_CTRL, 32'h1);
		wr(OFF_PRESCALE, 32'h9);
		op.press_confirm(HOLD + 8);
		chk(32'(restore_busy), 32'h1);
		chk(32'({led_red, local_led, remote_led, ready_green, ready_red}),
			32'hFFFFC);
		for (int i = 0; restore_busy === 1'b1; i++)
			if (i < 40) @(posedge aclk); else hang();
		cyc(3);
		chk(32'({led_red, remote_led, ready_red}), 32'h0);
		rd(OFF_CTRL);
		chk(rv, 32'h0);
		rd(OFF_PRESCALE);
		chk(rv, 32'h4);
		blinks(1);
	endtask : t_restore

	initial
	begin
		n_errors = 0;
		n_compared = 0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, di_pin} = 56'h0;
		s_axi_wstrb = 4'hF;
		cyc(20);
		aresetn <= 1'b1;
		cyc(2);
		blinks(1);
		t_regs();
		t_gates();
		t_latch();
		t_ready();
		t_cmd();
		t_restore();
		report_and_stop();
	end
endmodule : front_panel_tb

bind front_panel front_panel_props #(.NUM_CMD(NUM_CMD),
	.HOLD_CYCLES(HOLD_CYCLES), .RESTORE_CYCLES(RESTORE_CYCLES)) props (.*);
